// ==== logic/emon_consts.svh ====
`ifndef EMON_CONSTS_SVH
`define EMON_CONSTS_SVH

// Register byte offsets on the bus.
`define EMON_OFF_CTRL      8'h00
`define EMON_OFF_LOW_THR   8'h04
`define EMON_OFF_HIGH_THR  8'h08
`define EMON_OFF_FC_THR    8'h0c
`define EMON_OFF_STATUS    8'h10

// Field positions inside the threshold and status words.
`define EMON_MAX_LSB       16
`define EMON_RST_TH_LSB    4
`define EMON_FAIL_BIT      4
`define EMON_RST_FAIL_BIT  5
`define EMON_ERR_LVL_BIT   8

// Reset values, and the ceiling of the failure count.
`define EMON_CTRL_RST      4'h0
`define EMON_LMIN_RST      16'h0004
`define EMON_LMAX_RST      16'h0020
`define EMON_HMIN_RST      16'h0004
`define EMON_HMAX_RST      16'h0020
`define EMON_DRV_TH_RST    4'h5
`define EMON_RST_TH_RST    4'h7
`define EMON_FC_RST        4'h0
`define EMON_FC_MAX        4'hf

// Time base: one duration step of the pulse counter.
`define EMON_MCLK_PERIOD_NS 5
`define EMON_TICK_NS        1000

`endif

// ==== logic/emon_pkg.sv ====
package emon_pkg;

    // Operating state of the surrounding device.
    typedef enum logic [1:0] {
        DEV_RESET,
        DEV_DIAGNOSTIC,
        DEV_ACTIVE,
        DEV_SAFE
    } emon_dev_state_t;

    // Monitor sequencing states.
    typedef enum logic [2:0] {
        MON_IDLE,
        MON_WAIT_FALL,
        MON_STARTUP,
        MON_WAIT_EDGE,
        MON_PHASE1,
        MON_PHASE2
    } emon_mon_state_t;

    // Software control word.
    typedef struct packed {
        logic drive_req;
        logic rst_en;
        logic mode;
        logic enable;
    } emon_ctrl_t;

    // Phase bounds, in time-base steps.
    typedef struct packed {
        logic [15:0] max;
        logic [15:0] min;
    } emon_bounds_t;

endpackage

// ==== logic/emon_monitor.sv ====
`include "emon_consts.svh"

module emon_monitor
    import emon_pkg::*;
#(
    parameter int DUR_W = 16
) (
    input  wire logic            MCLK,
    input  wire logic            RESETN,
    input  wire logic            HSEL,
    input  wire logic [31:0]     HADDR,
    input  wire logic [1:0]      HTRANS,
    input  wire logic            HWRITE,
    input  wire logic [2:0]      HSIZE,
    input  wire logic [31:0]     HWDATA,
    input  wire logic            HREADY,
    output logic      [31:0]     HRDATA,
    output logic                 HREADYOUT,
    output logic                 HRESP,
    input  wire logic            ERR_IN,
    input  wire emon_dev_state_t DEV_STATE,
    input  wire logic            SELF_TEST_DONE,
    output logic                 SAFE_REQ,
    output logic                 RESET_REQ,
    output logic                 ENABLE_DRIVE,
    output logic                 HOST_RESET_OUT,
    output logic                 HOST_RESET_OE
);

    localparam int TICK_CYCLES = `EMON_TICK_NS / `EMON_MCLK_PERIOD_NS;
    localparam int CW          = DUR_W + 1;

    // The threshold fields are 16 bits wide, so DUR_W cannot be wider; the counter carries one bit more.
    initial begin
        if (DUR_W < 2 || DUR_W > 16) begin
            $error("DUR_W must lie between 2 and 16");
        end
        if (TICK_CYCLES < 1 || TICK_CYCLES > 256) begin
            $error("Time base step must lie between 1 and 256 clocks");
        end
    end

    // Software-visible state.
    emon_ctrl_t   ctrl;
    emon_bounds_t low_thr;
    emon_bounds_t high_thr;
    logic [3:0]   drv_th;
    logic [3:0]   rst_th;
    logic [3:0]   fc;
    logic         fail_flag;
    logic         rst_fail_flag;

    // Bus data phase bookkeeping.
    logic         wr_pend;
    logic [7:0]   wr_addr;

    // Error input synchroniser and edge history.
    logic         err_s1;
    logic         err_s2;
    logic         err_q;

    // Monitor sequencing.
    emon_mon_state_t state;
    emon_mon_state_t next_state;
    logic [CW-1:0]   dur;
    logic [CW-1:0]   next_dur;
    logic            lvl;
    logic            next_lvl;
    logic            ev_err;
    logic            ev_ok;
    logic [7:0]      pre;
    logic            mode_q;
    logic            en_q;
    emon_dev_state_t dev_q;

    // Bus address phase decode; the slave never waits and always answers OKAY.
    wire        addr_take = HSEL & HTRANS[1] & HREADY;
    wire [7:0]  a_off     = HADDR[7:0];
    wire        hit_ctrl  = a_off == `EMON_OFF_CTRL;
    wire        hit_low   = a_off == `EMON_OFF_LOW_THR;
    wire        hit_high  = a_off == `EMON_OFF_HIGH_THR;
    wire        hit_fcth  = a_off == `EMON_OFF_FC_THR;
    wire        hit_stat  = a_off == `EMON_OFF_STATUS;
    wire [31:0] stat_word = {23'h0, err_s2, 2'h0, rst_fail_flag, fail_flag, fc};
    wire [31:0] rd_word   = hit_ctrl ? {28'h0, ctrl} :
                            hit_low  ? low_thr :
                            hit_high ? high_thr :
                            hit_fcth ? {24'h0, rst_th, drv_th} :
                            hit_stat ? stat_word : 32'h0;
    wire        wr_ctrl   = wr_pend & (wr_addr == `EMON_OFF_CTRL);
    wire        wr_low    = wr_pend & (wr_addr == `EMON_OFF_LOW_THR);
    wire        wr_high   = wr_pend & (wr_addr == `EMON_OFF_HIGH_THR);
    wire        wr_fcth   = wr_pend & (wr_addr == `EMON_OFF_FC_THR);

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // Address phase capture and read data; read data are prepared in the
    // address phase so that they come from flip-flops in the data phase.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA  <= 32'h0;
        end else begin
            wr_pend <= addr_take & HWRITE;
            wr_addr <= a_off;
            HRDATA  <= (addr_take & ~HWRITE) ? rd_word : 32'h0;
        end
    end

    // Configuration registers, written in the data phase.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl     <= emon_ctrl_t'(`EMON_CTRL_RST);
            low_thr  <= {`EMON_LMAX_RST, `EMON_LMIN_RST};
            high_thr <= {`EMON_HMAX_RST, `EMON_HMIN_RST};
            drv_th   <= `EMON_DRV_TH_RST;
            rst_th   <= `EMON_RST_TH_RST;
        end else begin
            if (wr_ctrl) ctrl <= emon_ctrl_t'(HWDATA[3:0]);
            if (wr_low) low_thr <= HWDATA;
            if (wr_high) high_thr <= HWDATA;
            if (wr_fcth) begin
                drv_th <= HWDATA[3:0];
                rst_th <= HWDATA[`EMON_RST_TH_LSB +: 4];
            end
        end
    end

    // Two flops before anything reads the pin; err_q is the third stage for edges.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            err_s1 <= 1'b1;
            err_s2 <= 1'b1;
            err_q  <= 1'b1;
        end else begin
            err_s1 <= ERR_IN;
            err_s2 <= err_s1;
            err_q  <= err_s2;
        end
    end

    wire rise     = err_s2 & ~err_q;
    wire fall     = ~err_s2 & err_q;
    wire any_edge = rise | fall;

    // Time base prescaler; a free-running step costs up to one step of accuracy.
    wire tick = pre == 8'(TICK_CYCLES - 1);

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pre <= 8'h00;
        end else begin
            pre <= tick ? 8'h00 : 8'(pre + 8'h01);
        end
    end

    // Bounds of the phase now being measured, and the start-up timeout.
    wire [CW-1:0] lmin_w     = CW'(low_thr.min[DUR_W-1:0]);
    wire [CW-1:0] lmax_w     = CW'(low_thr.max[DUR_W-1:0]);
    wire [CW-1:0] hmin_w     = CW'(high_thr.min[DUR_W-1:0]);
    wire [CW-1:0] hmax_w     = CW'(high_thr.max[DUR_W-1:0]);
    wire [CW-1:0] startup_to = CW'(lmax_w + hmax_w);
    wire [CW-1:0] cur_min    = lvl ? hmin_w : lmin_w;
    wire [CW-1:0] cur_max    = lvl ? hmax_w : lmax_w;
    wire          too_long   = dur > cur_max;
    wire          in_bounds  = ~ctrl.mode | (dur >= cur_min);
    wire [CW-1:0] dur_inc    = (dur == {CW{1'b1}}) ? dur : CW'(dur + 1'b1);

    // Monitor sequencing; a fresh event starts after every verdict.
    always_comb begin
        next_state = state;
        next_lvl   = lvl;
        next_dur   = tick ? dur_inc : dur;
        ev_err     = 1'b0;
        ev_ok      = 1'b0;
        unique case (state)
            MON_IDLE: begin
                next_dur = '0;
                if (ctrl.enable) begin
                    if (ctrl.mode) begin
                        next_state = MON_WAIT_EDGE;
                    end else begin
                        next_state = err_s2 ? MON_WAIT_FALL : MON_STARTUP;
                    end
                end
            end
            MON_WAIT_FALL: begin
                next_dur = '0;
                if (fall) begin
                    next_state = MON_PHASE1;
                    next_lvl   = 1'b0;
                end
            end
            MON_STARTUP: begin
                if (rise) begin
                    next_state = MON_WAIT_FALL;
                end else if (dur > startup_to) begin
                    ev_err   = 1'b1;
                    next_dur = '0;
                end
            end
            MON_WAIT_EDGE: begin
                if (any_edge) begin
                    next_state = MON_PHASE1;
                    next_lvl   = err_s2;
                    next_dur   = '0;
                end else if (dur > startup_to) begin
                    ev_err   = 1'b1;
                    next_dur = '0;
                end
            end
            MON_PHASE1: begin
                if (any_edge) begin
                    next_dur = '0;
                    next_lvl = err_s2;
                    if (!ctrl.mode) begin
                        ev_ok      = 1'b1;
                        next_state = MON_WAIT_FALL;
                    end else if (in_bounds) begin
                        next_state = MON_PHASE2;
                    end else begin
                        ev_err = 1'b1;
                    end
                end else if (too_long) begin
                    ev_err   = 1'b1;
                    next_dur = '0;
                end
            end
            MON_PHASE2: begin
                if (any_edge) begin
                    next_dur   = '0;
                    next_lvl   = err_s2;
                    next_state = MON_PHASE1;
                    ev_ok      = in_bounds;
                    ev_err     = ~in_bounds;
                end else if (too_long) begin
                    ev_err     = 1'b1;
                    next_dur   = '0;
                    next_state = MON_PHASE1;
                end
            end
        endcase
    end

    // Events that restart the cycle, clear the count, or clear the flags.
    wire reset_entry    = (DEV_STATE == DEV_RESET) & (dev_q != DEV_RESET);
    wire diag_from_safe = (DEV_STATE == DEV_DIAGNOSTIC) & (dev_q == DEV_SAFE);
    wire mode_chg       = ctrl.mode != mode_q;
    wire en_rise        = ctrl.enable & ~en_q;
    wire en_fall        = ~ctrl.enable & en_q;
    wire restart        = reset_entry | SELF_TEST_DONE | mode_chg | ~ctrl.enable;
    wire flag_clear     = reset_entry | SELF_TEST_DONE | mode_chg | en_fall;
    wire fc_clear       = flag_clear | en_rise | diag_from_safe;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state  <= MON_IDLE;
            dur    <= '0;
            lvl    <= 1'b1;
            mode_q <= 1'b0;
            en_q   <= 1'b0;
            dev_q  <= DEV_RESET;
        end else begin
            state  <= restart ? MON_IDLE : next_state;
            dur    <= restart ? '0 : next_dur;
            lvl    <= next_lvl;
            mode_q <= ctrl.mode;
            en_q   <= ctrl.enable;
            dev_q  <= DEV_STATE;
        end
    end

    // Failure counter, saturating at both ends.
    wire [3:0] fc_up   = (fc == `EMON_FC_MAX) ? fc : 4'(fc + 4'h1);
    wire [3:0] fc_down = (fc == 4'h0) ? fc : 4'(fc - 4'h1);
    wire       mon_err = ev_err & ~restart;
    wire       mon_ok  = ev_ok & ~restart;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            fc <= `EMON_FC_RST;
        end else if (fc_clear) begin
            fc <= `EMON_FC_RST;
        end else if (mon_err) begin
            fc <= fc_up;
        end else if (mon_ok) begin
            fc <= fc_down;
        end
    end

    // Threshold evaluation. Nothing trips in SAFE, so a crossing there is idle.
    wire in_active  = DEV_STATE == DEV_ACTIVE;
    wire in_diag    = DEV_STATE == DEV_DIAGNOSTIC;
    wire over_drv   = fc > drv_th;
    wire over_rst   = fc > rst_th;
    wire rst_le_drv = rst_th <= drv_th;
    wire safe_trip  = ~ctrl.rst_en & ((in_active & over_drv) | ((in_active | in_diag) & over_rst));
    wire reset_trip = ctrl.rst_en & over_rst & (in_diag | (in_active & rst_le_drv));
    wire drive_ok   = ctrl.drive_req & (in_active | in_diag) & ~over_drv & ~safe_trip;

    // Requests and flags; a trip in the same cycle as a clear keeps the flag set.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            SAFE_REQ      <= 1'b0;
            RESET_REQ     <= 1'b0;
            ENABLE_DRIVE  <= 1'b0;
            fail_flag     <= 1'b0;
            rst_fail_flag <= 1'b0;
        end else begin
            SAFE_REQ      <= safe_trip;
            RESET_REQ     <= reset_trip;
            ENABLE_DRIVE  <= drive_ok;
            fail_flag     <= (safe_trip | reset_trip) | (fail_flag & ~flag_clear);
            rst_fail_flag <= (safe_trip | reset_trip) | (rst_fail_flag & ~flag_clear);
        end
    end

    // Open-drain host reset: only ever pulls low.
    assign HOST_RESET_OUT = 1'b0;
    assign HOST_RESET_OE  = RESET_REQ;

    property p_disabled_idle;
        @(posedge MCLK) disable iff (!RESETN)
        !ctrl.enable |=> state == MON_IDLE;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)
        else $error("Monitor left idle while disabled");

    property p_err_count;
        @(posedge MCLK) disable iff (!RESETN)
        (mon_err && !fc_clear && fc != `EMON_FC_MAX) |=> fc == 4'($past(fc) + 4'h1);
    endproperty
    a_err_count: assert property (p_err_count)
        else $error("Failure count did not rise after an error");

    property p_ok_count;
        @(posedge MCLK) disable iff (!RESETN)
        (mon_ok && !fc_clear && fc != 4'h0) |=> fc == 4'($past(fc) - 4'h1);
    endproperty
    a_ok_count: assert property (p_ok_count)
        else $error("Failure count did not fall after correct signalling");

    property p_saturate;
        @(posedge MCLK) disable iff (!RESETN)
        (fc == `EMON_FC_MAX && !fc_clear && !mon_ok) |=> fc == `EMON_FC_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("Failure count wrapped past fifteen");

    property p_safe_trip;
        @(posedge MCLK) disable iff (!RESETN)
        (in_active && !ctrl.rst_en && over_drv) |=> SAFE_REQ && !ENABLE_DRIVE && fail_flag && rst_fail_flag;
    endproperty
    a_safe_trip: assert property (p_safe_trip)
        else $error("Drive threshold crossing did not force safe");

    property p_reset_diag;
        @(posedge MCLK) disable iff (!RESETN)
        (in_diag && ctrl.rst_en && over_rst) |=> RESET_REQ && HOST_RESET_OE && fail_flag;
    endproperty
    a_reset_diag: assert property (p_reset_diag)
        else $error("Reset threshold crossing did not pull host reset");

    property p_no_active_reset;
        @(posedge MCLK) disable iff (!RESETN)
        (in_active && !rst_le_drv) |=> !RESET_REQ;
    endproperty
    a_no_active_reset: assert property (p_no_active_reset)
        else $error("Reset requested from active with reset threshold above drive threshold");

    property p_self_test_clear;
        @(posedge MCLK) disable iff (!RESETN)
        (SELF_TEST_DONE && !safe_trip && !reset_trip) |=> fc == `EMON_FC_RST && !fail_flag && state == MON_IDLE;
    endproperty
    a_self_test_clear: assert property (p_self_test_clear)
        else $error("Self-test completion did not reinitialise the monitor");

    property p_startup_timeout;
        @(posedge MCLK) disable iff (!RESETN)
        (state == MON_STARTUP && !rise && dur > startup_to && !restart) |=> dur == '0 && $past(mon_err);
    endproperty
    a_startup_timeout: assert property (p_startup_timeout)
        else $error("Start-up timeout did not flag an error and restart");

endmodule

// ==== dv/emon_host_model.sv ====
// Stands in for the host that drives the error pin; push-pull, so the pin always shows a driven level.
module emon_host_model #(
    parameter int SHORT = 60
) (
    input  wire logic MCLK,
    output logic      ERR_PIN
);
    timeunit 1ns;
    timeprecision 100ps;

    // The pin idles high until the bench commands a phase.
    initial ERR_PIN = 1'b1;

    // Holds one level for n cycles; the caller picks lengths inside or outside the bounds.
    task automatic phase(input logic lvl, input int n);
        @(posedge MCLK);
        ERR_PIN <= lvl;
        repeat (n - 1) @(posedge MCLK);
    endtask

    // Toggles every SHORT cycles, so each phase after the first breaks its minimum.
    task automatic burst(input int n);
        repeat (n) phase(~ERR_PIN, SHORT);
    endtask
endmodule

// ==== dv/emon_monitor_test.sv ====
`include "emon_consts.svh"

module emon_monitor_test
    import emon_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int STEP = `EMON_TICK_NS / `EMON_MCLK_PERIOD_NS;
    localparam int S    = 60;
    localparam int G    = 3 * STEP;
    localparam int W    = 4 * STEP;
    localparam int L    = 7 * STEP;

    typedef struct {
        logic       mode;
        logic       rst;
        logic       lvl;
        int         cyc;
        logic [3:0] fc;
    } emon_row_t;

    // Pin waveform in time order; fc is the count expected just after each row starts.
    emon_row_t rows [23] = '{
        '{1, 1, 1, G, 0}, '{1, 0, 0, G, 0}, '{1, 0, 1, G, 0}, '{1, 0, 0, S, 0}, '{1, 0, 1, S, 1},
        '{1, 0, 0, G, 2}, '{1, 0, 1, G, 2}, '{1, 0, 0, G, 1}, '{1, 0, 1, G, 1}, '{1, 0, 0, G, 0},
        '{1, 0, 1, L, 0}, '{1, 0, 1, S, 1}, '{1, 1, 1, L, 0}, '{1, 0, 1, W, 0}, '{1, 0, 1, S, 1},
        '{0, 0, 1, G, 0}, '{0, 0, 0, G, 0}, '{0, 0, 1, G, 0}, '{0, 0, 0, L, 0}, '{0, 0, 0, S, 1},
        '{0, 1, 0, L, 0}, '{0, 0, 0, W, 0}, '{0, 0, 0, S, 1}
    };
    logic [7:0]  raddr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rval  [6] = '{32'h0, {`EMON_LMAX_RST, `EMON_LMIN_RST}, {`EMON_HMAX_RST, `EMON_HMIN_RST},
                               {24'h0, `EMON_RST_TH_RST, `EMON_DRV_TH_RST}, 32'h100, 32'h0};

    logic            mclk      = 1'b0;
    logic            resetn    = 1'b0;
    logic            hsel      = 1'b0;
    logic [31:0]     haddr     = 32'h0;
    logic [1:0]      htrans    = 2'h0;
    logic            hwrite    = 1'b0;
    logic [31:0]     hwdata    = 32'h0;
    logic [2:0]      hsize     = 3'h0;
    emon_dev_state_t dev_state = DEV_DIAGNOSTIC;
    logic            st_done   = 1'b0;
    logic            cur_mode  = 1'b1;
    logic [31:0]     hrdata;
    logic [31:0]     rdata_q;
    logic [31:0]     rd;
    logic            hready;
    logic            hresp;
    logic            err_pin;
    logic            safe_req;
    logic            reset_req;
    logic            en_drv;
    logic            rst_out;
    logic            rst_oe;
    int              n_mismatch = 0;
    int              checks     = 0;

    // Free-running 200 MHz clock.
    always #2.5 mclk = ~mclk;

    // Read data is captured at the edge that closes the data phase.
    always @(posedge mclk) rdata_q <= hrdata;

    emon_monitor emon_monitor_i (
        .MCLK(mclk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .ERR_IN(err_pin), .DEV_STATE(dev_state), .SELF_TEST_DONE(st_done), .SAFE_REQ(safe_req),
        .RESET_REQ(reset_req), .ENABLE_DRIVE(en_drv), .HOST_RESET_OUT(rst_out), .HOST_RESET_OE(rst_oe)
    );

    emon_host_model emon_host_model_i (
        .MCLK   (mclk),
        .ERR_PIN(err_pin)
    );

    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; the address phase is held until hready, then the data phase.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        #1;
        rd = rdata_q;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic fc(input logic [3:0] exp);
        bus(1'b0, `EMON_OFF_STATUS, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, exp});
    endtask

    task automatic settle(input emon_dev_state_t st);
        @(posedge mclk);
        dev_state <= st;
        repeat (4) @(posedge mclk);
    endtask

    // Main sequence: table of pin waveforms, then threshold and reinit cases, then reset values.
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        bus(1'b1, `EMON_OFF_LOW_THR, {16'h0004, 16'h0002});
        bus(1'b1, `EMON_OFF_HIGH_THR, {16'h0004, 16'h0002});
        emon_host_model_i.burst(4);
        fc(4'h0);
        foreach (rows[i]) begin
            fork
                emon_host_model_i.phase(rows[i].lvl, rows[i].cyc);
                begin
                    if (rows[i].rst) bus(1'b1, `EMON_OFF_CTRL, 32'h0);
                    if (rows[i].rst || rows[i].mode !== cur_mode) bus(1'b1, `EMON_OFF_CTRL, {30'h0, rows[i].mode, 1'b1});
                    cur_mode = rows[i].mode;
                    repeat (30) @(posedge mclk);
                    fc(rows[i].fc);
                end
            join
        end
        // Trips: drive threshold 1, reset threshold 2, ACTIVE, drive request on.
        bus(1'b1, `EMON_OFF_FC_THR, 32'h21);
        settle(DEV_ACTIVE);
        emon_host_model_i.phase(1'b1, 4);
        bus(1'b1, `EMON_OFF_CTRL, 32'h0);
        bus(1'b1, `EMON_OFF_CTRL, 32'hb);
        // The drive output is registered one cycle behind the control write.
        @(posedge mclk);
        #1;
        chk({31'h0, en_drv}, 32'h1);
        emon_host_model_i.burst(3);
        bus(1'b0, `EMON_OFF_STATUS, 32'h0);
        chk(rd, 32'h32);
        chk({29'h0, safe_req, en_drv, reset_req}, 32'h4);
        emon_host_model_i.burst(1);
        settle(DEV_DIAGNOSTIC);
        chk({29'h0, safe_req, en_drv, reset_req}, 32'h4);
        bus(1'b1, `EMON_OFF_CTRL, 32'hf);
        @(posedge mclk);
        #1;
        chk({29'h0, safe_req, reset_req, rst_oe}, 32'h3);
        settle(DEV_ACTIVE);
        chk({30'h0, safe_req, reset_req}, 32'h0);
        settle(DEV_RESET);
        bus(1'b0, `EMON_OFF_STATUS, 32'h0);
        chk({25'h0, rd[5:0], reset_req}, 32'h0);
        settle(DEV_SAFE);
        emon_host_model_i.burst(4);
        fc(4'h3);
        chk({30'h0, safe_req, reset_req}, 32'h0);
        @(posedge mclk);
        st_done <= 1'b1;
        @(posedge mclk);
        st_done <= 1'b0;
        fc(4'h0);
        emon_host_model_i.burst(18);
        fc(4'hf);
        // Leaving SAFE for DIAGNOSTIC returns the count to its default.
        settle(DEV_DIAGNOSTIC);
        fc(4'h0);
        emon_host_model_i.burst(4);
        settle(DEV_ACTIVE);
        bus(1'b1, `EMON_OFF_FC_THR, 32'h13);
        repeat (3) @(posedge mclk);
        chk({29'h0, reset_req, rst_oe, rst_out}, 32'h6);
        // Second reset in mid-run while a reset request stands.
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({28'h0, safe_req, reset_req, en_drv, rst_oe}, 32'h0);
        @(posedge mclk);
        resetn <= 1'b1;
        bus(1'b1, `EMON_OFF_STATUS, 32'hffffffff);
        bus(1'b1, 8'h14, 32'hffffffff);
        foreach (raddr[i]) begin
            bus(1'b0, raddr[i], 32'h0);
            chk(rd, rval[i]);
        end
        complete_run();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (90000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end
endmodule
